/* File: rtl/ssrb_device.sv */
// Register bank end: serial slave, shadow and active copies
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module ssrb_device #(
	parameter logic [7:0] CHIP_ID = 8'hA5, // Arbitrary value
	parameter logic [7:0] CHIP_GRADE = 8'h00,
	parameter logic [ssrb_pkg::NUM_SHADOW-1:0] LOCAL_MASK = '1
) (
	input wire logic clk_sys,
	input wire logic rst,
	ssrb_spi_if.dev spi,
	output logic [ssrb_pkg::NUM_SHADOW*8-1:0] active_a,
	output logic [ssrb_pkg::NUM_SHADOW*8-1:0] active_b,
	output logic [1:0] chan_sel,
	output logic lsb_first,
	output logic xfer_pend
);
	// ==========================================
	// Pin synchronisers
	logic [1:0] csb_q;
	logic [2:0] sclk_q;
	logic [1:0] sdio_q;
	logic rise;
	logic fall;
	logic sel;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			csb_q <= 2'h3;
			sclk_q <= 3'h0;
			sdio_q <= 2'h3;
		end else begin
			csb_q <= {csb_q[0], spi.csb_n};
			sclk_q <= {sclk_q[1:0], spi.sclk};
			sdio_q <= {sdio_q[0], spi.sdio};
		end
	end

	assign rise = sclk_q[1] & ~sclk_q[2];
	assign fall = ~sclk_q[1] & sclk_q[2];
	assign sel = ~csb_q[1];

	// ==========================================
	// Frame shifter
	logic [4:0] bit_cnt;
	logic [15:0] instr;
	logic [6:0] wdat;
	logic [12:0] addr;
	logic rd;
	logic wr_stb;
	logic [7:0] wr_data;

	always_ff @(posedge clk_sys) begin
		if (rst || !sel) begin
			bit_cnt <= 5'h00;
		end else if (rise && bit_cnt != 5'(ssrb_pkg::FRAME_BITS)) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			instr <= 16'h0000;
			wdat <= 7'h00;
		end else if (rise && sel) begin
			if (bit_cnt < 5'(ssrb_pkg::INSTR_BITS)) begin
				instr <= {instr[14:0], sdio_q[1]};
			end else begin
				wdat <= {wdat[5:0], sdio_q[1]};
			end
		end
	end

	assign addr = instr[12:0];
	assign rd = instr[ssrb_pkg::RW_BIT];
	assign wr_data = {wdat, sdio_q[1]};
	assign wr_stb = rise && sel && !rd && bit_cnt == 5'(ssrb_pkg::FRAME_BITS - 1);

	// ==========================================
	// Global registers
	logic srst_pend;
	logic rst_all;
	logic wr_cfg;

	assign wr_cfg = wr_stb && addr == ssrb_pkg::A_PORT_CFG; // R12
	assign rst_all = rst | srst_pend; // R15

	// Soft reset request lives one cycle, then clears
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			srst_pend <= 1'b0;
		end else begin
			srst_pend <= wr_cfg && (wr_data[ssrb_pkg::PC_SRST_HI] || wr_data[ssrb_pkg::PC_SRST_LO]); // R15
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_all) begin
			lsb_first <= ssrb_pkg::RST_PORT_CFG[ssrb_pkg::PC_LSB_HI]; // R11
		end else if (wr_cfg) begin
			lsb_first <= wr_data[ssrb_pkg::PC_LSB_HI] | wr_data[ssrb_pkg::PC_LSB_LO]; // R14
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_all) begin
			chan_sel <= ssrb_pkg::RST_CHAN_IDX; // R13
		end else if (wr_stb && addr == ssrb_pkg::A_CHAN_IDX) begin
			chan_sel <= wr_data[1:0]; // R12
		end
	end

	// Transfer bit is a one-cycle pulse, so it reads back zero
	always_ff @(posedge clk_sys) begin
		if (rst_all) begin
			xfer_pend <= 1'b0;
		end else begin
			xfer_pend <= wr_stb && addr == ssrb_pkg::A_XFER && wr_data[ssrb_pkg::XFER_BIT]; // R03
		end
	end

	// ==========================================
	// Shadow and active copies per channel
	logic [7:0] shad [0:1][0:ssrb_pkg::NUM_SHADOW-1];
	logic [7:0] act [0:1][0:ssrb_pkg::NUM_SHADOW-1];
	logic [ssrb_pkg::NUM_SHADOW*8-1:0] act_flat [0:1];
	logic [4:0] sidx;
	logic s_hit;
	logic s_local;

	assign sidx = ssrb_pkg::shadow_idx(addr);
	assign s_hit = ssrb_pkg::is_shadow(addr);
	assign s_local = LOCAL_MASK[sidx];

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		// Local entries follow the select bit; global ones take every write
		always_ff @(posedge clk_sys) begin
			if (rst_all) begin
				for (int i = 0; i < ssrb_pkg::NUM_SHADOW; i++) begin
					shad[ch][i] <= ssrb_pkg::shadow_default(i); // R11
				end
			end else if (wr_stb && s_hit && (chan_sel[ch] || !s_local)) begin // R04 R05 R08
				shad[ch][sidx] <= wr_data; // R01
			end
		end

		// All entries commit together on the transfer pulse
		always_ff @(posedge clk_sys) begin
			if (rst_all) begin
				for (int i = 0; i < ssrb_pkg::NUM_SHADOW; i++) begin
					act[ch][i] <= ssrb_pkg::shadow_default(i); // R11
				end
			end else if (xfer_pend) begin
				act[ch] <= shad[ch]; // R02
			end
		end

		for (genvar i = 0; i < ssrb_pkg::NUM_SHADOW; i++) begin : g_ent
			assign act_flat[ch][i*8 +: 8] = act[ch][i];
		end
	end

	assign active_a = act_flat[0];
	assign active_b = act_flat[1];

	// ==========================================
	// Read multiplexer
	logic [7:0] rd_val;
	logic use_b;

	assign use_b = s_local && !chan_sel[ssrb_pkg::CI_A] && chan_sel[ssrb_pkg::CI_B]; // R06

	always_comb begin
		rd_val = 8'h00;
		if (s_hit) begin
			rd_val = use_b ? shad[1][sidx] : shad[0][sidx];
		end else begin
			unique case (addr)
				ssrb_pkg::A_PORT_CFG: begin
					rd_val = {1'b0, lsb_first, srst_pend, 2'h3, srst_pend, lsb_first, 1'b0}; // R14
				end
				ssrb_pkg::A_CHIP_ID: begin
					rd_val = CHIP_ID;
				end
				ssrb_pkg::A_CHIP_GRADE: begin
					rd_val = CHIP_GRADE;
				end
				ssrb_pkg::A_CHAN_IDX: begin
					rd_val = {6'h00, chan_sel};
				end
				ssrb_pkg::A_XFER: begin
					rd_val = {7'h00, xfer_pend}; // R03
				end
				default: begin
					rd_val = 8'h00;
				end
			endcase
		end
	end

	// ==========================================
	// Read-back driver, changes after falling clock
	logic [6:0] rd_sh;

	always_ff @(posedge clk_sys) begin
		if (rst || !sel) begin
			spi.sdio_dev_oe <= 1'b0;
			spi.sdio_dev_out <= 1'b0;
			rd_sh <= 7'h00;
		end else if (fall && rd && bit_cnt >= 5'(ssrb_pkg::INSTR_BITS)
			&& bit_cnt < 5'(ssrb_pkg::FRAME_BITS)) begin
			spi.sdio_dev_oe <= 1'b1;
			if (bit_cnt == 5'(ssrb_pkg::INSTR_BITS)) begin
				spi.sdio_dev_out <= rd_val[7];
				rd_sh <= rd_val[6:0];
			end else begin
				spi.sdio_dev_out <= rd_sh[6];
				rd_sh <= {rd_sh[5:0], 1'b0};
			end
		end
	end
endmodule : ssrb_device

/* File: rtl/ssrb_pkg.sv */
// Constants, address map and helpers of the shadowed register bank
// Contract
// R01 - Function and feature writes held in shadow
// R02 - Writing 0x01 to 0xFF commits all shadows
// R03 - Transfer bit clears itself after update
// R04 - Local registers exist once per channel
// R05 - Both selects set: write reaches both
// R06 - Both selects set: read returns channel A
// R07 - Host reads local with one select set; host refuses such reads only when both selects are set
// R08 - Global registers ignore the channel selects
// R09 - Host writes zeros into undefined bits
// R10 - Host never writes unsupported addresses
// R11 - Reset loads defaults, port config 0x18
// R12 - Config 0x00-0x02, index 0x05, transfer 0xFF
// R13 - Channel index resets to 0x03
// R14 - Port config flags mirrored, fixed bits
// R15 - Soft reset restores defaults, then clears
package ssrb_pkg;
	// ==========================================
	// Frame layout
	localparam int ADDR_W = 13;
	localparam int FRAME_BITS = 24;
	localparam int INSTR_BITS = 16;
	localparam int RW_BIT = 15;
	// ==========================================
	// Address map
	localparam logic [12:0] A_PORT_CFG = 13'h0000;
	localparam logic [12:0] A_CHIP_ID = 13'h0001;
	localparam logic [12:0] A_CHIP_GRADE = 13'h0002;
	localparam logic [12:0] A_CHAN_IDX = 13'h0005;
	localparam logic [12:0] A_XFER = 13'h00FF;
	localparam logic [12:0] A_FUNC_LO = 13'h0008;
	localparam logic [12:0] A_FUNC_HI = 13'h0020;
	localparam logic [12:0] A_DIG_LO = 13'h003A;
	localparam logic [12:0] A_DIG_HI = 13'h003E;
	localparam logic [12:0] A_OUT_MODE = 13'h0014;
	localparam int NUM_SHADOW = 30;
	localparam int DIG_BASE = 25;
	// ==========================================
	// Reset values and fields
	localparam logic [7:0] RST_PORT_CFG = 8'h18;
	localparam logic [1:0] RST_CHAN_IDX = 2'h3;
	localparam logic [7:0] RST_OUT_MODE = 8'h05;
	localparam logic [7:0] RST_SHADOW = 8'h00;
	localparam logic [7:0] XFER_CMD = 8'h01;
	localparam int PC_LSB_HI = 6;
	localparam int PC_LSB_LO = 1;
	localparam int PC_SRST_HI = 5;
	localparam int PC_SRST_LO = 2;
	localparam int CI_A = 0;
	localparam int CI_B = 1;
	localparam int XFER_BIT = 0;
	// ==========================================
	// Host register port
	localparam logic [2:0] HR_ADDR = 3'h0;
	localparam logic [2:0] HR_WDATA = 3'h1;
	localparam logic [2:0] HR_CTRL = 3'h2;
	localparam logic [2:0] HR_STATUS = 3'h3;
	localparam logic [2:0] HR_RDATA = 3'h4;
	localparam int CT_START = 0;
	localparam int CT_READ = 1;
	localparam int CT_XFER = 2;
	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_HALF_NS = 64;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================
	// Helpers
	function automatic logic is_shadow(input logic [12:0] a);
		return (a >= A_FUNC_LO && a <= A_FUNC_HI) || (a >= A_DIG_LO && a <= A_DIG_HI);
	endfunction : is_shadow
	function automatic logic [4:0] shadow_idx(input logic [12:0] a);
		if (a >= A_DIG_LO) begin
			return 5'(a - A_DIG_LO + 13'(DIG_BASE));
		end
		return 5'(a - A_FUNC_LO);
	endfunction : shadow_idx
	function automatic logic [7:0] shadow_default(input int i);
		return (i == int'(A_OUT_MODE - A_FUNC_LO)) ? RST_OUT_MODE : RST_SHADOW;
	endfunction : shadow_default
	function automatic logic supported(input logic [12:0] a);
		return a <= A_CHIP_GRADE || a == A_CHAN_IDX || a == A_XFER || is_shadow(a);
	endfunction : supported
	function automatic logic [7:0] defined_mask(input logic [12:0] a);
		if (a == A_CHAN_IDX) begin
			return 8'h03;
		end
		if (a == A_XFER) begin
			return 8'h01;
		end
		if (a == A_PORT_CFG) begin
			return 8'h7E;
		end
		return 8'hFF;
	endfunction : defined_mask
endpackage : ssrb_pkg

/* File: rtl/ssrb_spi_if.sv */
// Three-wire serial link between host and register bank
`timescale 1ns/1ps
interface ssrb_spi_if;
	logic csb_n;
	logic sclk;
	logic sdio_host_out;
	logic sdio_host_oe;
	logic sdio_dev_out;
	logic sdio_dev_oe;
	logic sdio;
	// Wire level with pull-up when nobody drives
	assign sdio = sdio_host_oe ? sdio_host_out : (sdio_dev_oe ? sdio_dev_out : 1'b1);
	modport dev (
		input csb_n,
		input sclk,
		input sdio,
		output sdio_dev_out,
		output sdio_dev_oe
	);
	modport host (
		output csb_n,
		output sclk,
		output sdio_host_out,
		output sdio_host_oe,
		input sdio
	);
endinterface : ssrb_spi_if

/* File: rtl/ssrb_host.sv */
// Host end: register port in, serial frames out
`timescale 1ns/1ps
module ssrb_host #(
	parameter int HALF_CYC = ssrb_pkg::SCLK_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	ssrb_spi_if.host spi,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOW = 4'b0010,
		ST_HIGH = 4'b0100,
		ST_FIN = 4'b1000
	} ssrb_hst_t;

	// ==========================================
	// Registers and command decode
	ssrb_hst_t state;
	logic [12:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] rdata_r;
	logic [7:0] rx;
	logic done;
	logic err;
	logic [1:0] chan_track;
	logic [1:0] sdio_q;
	logic [23:0] shreg;
	logic [4:0] cnt;
	logic [7:0] timer;
	logic is_rd;
	logic start;
	logic c_rd;
	logic c_xfer;
	logic [12:0] t_addr;
	logic [7:0] t_data;
	logic refuse;
	logic launch;
	logic tick;

	assign start = reg_wr && reg_addr == ssrb_pkg::HR_CTRL && reg_wdata[ssrb_pkg::CT_START]
		&& state == ST_IDLE;
	assign c_xfer = reg_wdata[ssrb_pkg::CT_XFER];
	assign c_rd = reg_wdata[ssrb_pkg::CT_READ] && !c_xfer;
	assign t_addr = c_xfer ? ssrb_pkg::A_XFER : addr_r; // R02
	assign t_data = c_xfer ? ssrb_pkg::XFER_CMD : (wdata_r & ssrb_pkg::defined_mask(addr_r)); // R09
	assign refuse = (!c_rd && !ssrb_pkg::supported(t_addr)) // R10
		|| (c_rd && chan_track == 2'h3 && ssrb_pkg::is_shadow(addr_r)); // R07
	assign launch = start && !refuse;
	assign tick = timer == 8'(HALF_CYC - 1);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			addr_r <= 13'h0000;
			wdata_r <= 8'h00;
		end else if (reg_wr && reg_addr == ssrb_pkg::HR_ADDR) begin
			addr_r <= reg_wdata[12:0];
		end else if (reg_wr && reg_addr == ssrb_pkg::HR_WDATA) begin
			wdata_r <= reg_wdata[7:0];
		end
	end

	// Mirror of the bank's channel index as last written
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chan_track <= ssrb_pkg::RST_CHAN_IDX;
		end else if (launch && !c_rd && t_addr == ssrb_pkg::A_CHAN_IDX) begin
			chan_track <= t_data[1:0];
		end else if (launch && !c_rd && t_addr == ssrb_pkg::A_PORT_CFG
			&& (t_data[ssrb_pkg::PC_SRST_HI] || t_data[ssrb_pkg::PC_SRST_LO])) begin
			chan_track <= ssrb_pkg::RST_CHAN_IDX;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done <= 1'b0;
			err <= 1'b0;
		end else if (start) begin
			done <= refuse;
			err <= refuse;
		end else if (state == ST_FIN && tick) begin
			done <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ssrb_pkg::HR_ADDR: reg_rdata <= {3'h0, addr_r};
				ssrb_pkg::HR_WDATA: reg_rdata <= {8'h00, wdata_r};
				ssrb_pkg::HR_STATUS: reg_rdata <= {13'h0000, err, done, state != ST_IDLE};
				ssrb_pkg::HR_RDATA: reg_rdata <= {8'h00, rdata_r};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ==========================================
	// Serial frame engine
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sdio_q <= 2'h3;
		end else begin
			sdio_q <= {sdio_q[0], spi.sdio};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_IDLE;
			spi.csb_n <= 1'b1;
			spi.sclk <= 1'b0;
			spi.sdio_host_oe <= 1'b0;
			shreg <= 24'h000000;
			cnt <= 5'h00;
			timer <= 8'h00;
			is_rd <= 1'b0;
			rx <= 8'h00;
			rdata_r <= 8'h00;
		end else begin
			timer <= tick ? 8'h00 : timer + 8'h01;
			unique case (state)
				ST_IDLE: begin
					timer <= 8'h00;
					if (launch) begin
						state <= ST_LOW;
						spi.csb_n <= 1'b0;
						spi.sdio_host_oe <= 1'b1;
						shreg <= {c_rd, 2'h0, t_addr, c_rd ? 8'h00 : t_data};
						is_rd <= c_rd;
						cnt <= 5'h00;
					end
				end
				ST_LOW: begin
					if (tick) begin
						state <= ST_HIGH;
						spi.sclk <= 1'b1;
					end
				end
				ST_HIGH: begin
					if (tick) begin
						spi.sclk <= 1'b0;
						shreg <= {shreg[22:0], 1'b0};
						cnt <= cnt + 5'h01;
						if (is_rd && cnt == 5'(ssrb_pkg::INSTR_BITS - 1)) begin
							spi.sdio_host_oe <= 1'b0;
						end
						if (is_rd && cnt >= 5'(ssrb_pkg::INSTR_BITS)) begin
							rx <= {rx[6:0], sdio_q[1]};
						end
						if (cnt == 5'(ssrb_pkg::FRAME_BITS - 1)) begin
							state <= ST_FIN;
							spi.csb_n <= 1'b1;
							spi.sdio_host_oe <= 1'b0;
							if (is_rd) begin
								rdata_r <= {rx[6:0], sdio_q[1]};
							end
						end else begin
							state <= ST_LOW;
						end
					end
				end
				ST_FIN: begin
					if (tick) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign spi.sdio_host_out = shreg[23];
endmodule : ssrb_host

/* File: testbench/ssrb_link_props.sv */
// Concurrent checks on the serial link between host and register bank
`timescale 1ns/1ps
module ssrb_link_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic csb_n,
	input wire logic sclk,
	input wire logic sdio_host_out,
	input wire logic sdio_host_oe,
	input wire logic sdio_dev_out,
	input wire logic sdio_dev_oe,
	input wire logic sdio
);
	// ========================================
	// Frame tracking
	logic sclk_q;
	logic rw;
	logic [5:0] cnt;
	logic rise;
	assign rise = sclk && !sclk_q;
	always_ff @(posedge clk_sys) begin
		sclk_q <= sclk;
	end
	always_ff @(posedge clk_sys) begin
		if (rst || csb_n) begin
			cnt <= 6'h00;
		end else if (rise) begin
			cnt <= cnt + 6'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst || csb_n) begin
			rw <= 1'b0;
		end else if (rise && cnt == 6'h00) begin
			rw <= sdio;
		end
	end
	// ========================================
	// Properties
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_reset_idle: assert property (disable iff (1'b0)
		rst |=> csb_n && !sclk && !sdio_host_oe && !sdio_dev_oe) else $error("link busy in reset");
	a_idle_sclk_low: assert property (csb_n [*2] |-> !sclk)
		else $error("serial clock runs outside frame");
	a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("serial clock high phase wrong");
	a_frame_bits: assert property ($rose(csb_n) |-> cnt == 6'h18)
		else $error("frame not 24 bits");
	a_dev_read_only: assert property ((sdio_dev_oe && !csb_n) |-> rw && cnt >= 6'h10)
		else $error("device drives outside read data");
	a_dev_off_idle: assert property (csb_n [*6] |-> !sdio_dev_oe)
		else $error("device drives while deselected");
	a_write_host_drv: assert property ((!csb_n && !rw && cnt != 6'h00 && cnt < 6'h18)
		|-> sdio_host_oe) else $error("host released write frame");
	a_read_host_off: assert property ((!csb_n && rw && cnt > 6'h10) |-> !sdio_host_oe)
		else $error("host drives read data");
	a_no_clash: assert property (!(sdio_host_oe && sdio_dev_oe))
		else $error("both ends drive data line");
	a_wire_level: assert property ((sdio_dev_oe && !sdio_host_oe) |-> sdio == sdio_dev_out)
		else $error("data line not device level");
	a_host_level: assert property (sdio_host_oe |-> sdio == sdio_host_out)
		else $error("data line not host level");
	c_write_frame: cover property ($rose(csb_n) && !rw);
	c_read_frame: cover property ($rose(csb_n) && rw);
	c_dev_drive: cover property (sdio_dev_oe && !sdio_host_oe);
endmodule : ssrb_link_props

/* File: testbench/shadowed_spi_register_bank_tb.sv */
// Bench: host and register bank joined over the serial link
`timescale 1ns/1ps
module shadowed_spi_register_bank_tb;
	// ========================================
	// Signals and instances
	localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary value
	localparam logic [7:0] GRADE_VAL = 8'h20;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [239:0] active_a;
	logic [239:0] active_b;
	logic [1:0] chan_sel;
	logic lsb_first;
	logic xfer_pend;
	logic xfer_seen = 1'b0;
	logic [23:0] frame = 24'h000000;
	logic [7:0] sh_a [30];
	logic [7:0] sh_b [30];
	logic [7:0] act_a [30];
	logic [7:0] act_b [30];
	logic [1:0] chan;
	logic [7:0] pcfg;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	ssrb_spi_if ssrb_spi_if_inst ();
	ssrb_host #(.HALF_CYC(8)) ssrb_host_inst (.clk_sys(clk_sys), .rst(rst),
		.spi(ssrb_spi_if_inst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	ssrb_device #(.CHIP_ID(ID_VAL), .CHIP_GRADE(GRADE_VAL)) ssrb_device_inst (.clk_sys(clk_sys),
		.rst(rst), .spi(ssrb_spi_if_inst), .active_a(active_a), .active_b(active_b),
		.chan_sel(chan_sel), .lsb_first(lsb_first), .xfer_pend(xfer_pend));
	ssrb_link_props ssrb_link_props_inst (.clk_sys(clk_sys), .rst(rst),
		.csb_n(ssrb_spi_if_inst.csb_n), .sclk(ssrb_spi_if_inst.sclk),
		.sdio_host_out(ssrb_spi_if_inst.sdio_host_out),
		.sdio_host_oe(ssrb_spi_if_inst.sdio_host_oe),
		.sdio_dev_out(ssrb_spi_if_inst.sdio_dev_out),
		.sdio_dev_oe(ssrb_spi_if_inst.sdio_dev_oe), .sdio(ssrb_spi_if_inst.sdio));
	// ========================================
	// Clock, wire monitor, timeout
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge ssrb_spi_if_inst.sclk) begin
		if (!ssrb_spi_if_inst.csb_n) begin
			frame <= {frame[22:0], ssrb_spi_if_inst.sdio};
		end
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (xfer_pend === 1'b1) begin
			xfer_seen <= 1'b1;
		end
		if (cycles == 40000) begin
			mismatches++;
			test_done();
		end
	end
	// ========================================
	// Tasks
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic spi(input logic [1:0] r, input logic [12:0] a, input logic [7:0] d,
		input logic [2:0] est, output logic [7:0] q);
		logic [15:0] st;
		int n;
		wr(3'h0, {3'h0, a});
		wr(3'h1, {8'h00, d});
		wr(3'h2, {13'h0000, r, 1'b1});
		repeat (2) @(posedge clk_sys);
		st = 16'h0001;
		n = 0;
		while (st[0] !== 1'b0 && n < 500) begin
			rd(3'h3, st);
			n++;
		end
		chk(24'(st[2:0]), 24'(est));
		rd(3'h4, st);
		q = st[7:0];
	endtask : spi
	task automatic mreset();
		for (int i = 0; i < 30; i++) begin
			sh_a[i] = (i == 12) ? 8'h05 : 8'h00;
			sh_b[i] = sh_a[i];
		end
		act_a = sh_a;
		act_b = sh_a;
		chan = 2'h3;
		pcfg = 8'h18;
	endtask : mreset
	task automatic cact();
		chk(24'(chan_sel), 24'(chan));
		for (int i = 0; i < 30; i++) begin
			chk(24'(active_a[i*8+:8]), 24'(act_a[i]));
			chk(24'(active_b[i*8+:8]), 24'(act_b[i]));
		end
	endtask : cact
	task automatic dw(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] q;
		int i;
		int n;
		d = d & ((a == 13'h0005) ? 8'h03 : (a == 13'h00FF) ? 8'h01 : (a == 13'h0000) ? 8'h7E : 8'hFF);
		xfer_seen = 1'b0;
		spi(2'h0, a, d, 3'b010, q);
		chk(frame, {3'b000, a, d});
		i = (a >= 13'h003A) ? int'(a) - 33 : int'(a) - 8;
		if (a == 13'h0005) begin
			chan = d[1:0];
		end
		if ((a >= 13'h0008 && a <= 13'h0020) || (a >= 13'h003A && a <= 13'h003E)) begin
			sh_a[i] = chan[0] ? d : sh_a[i];
			sh_b[i] = chan[1] ? d : sh_b[i];
		end
		if (a == 13'h0000) begin
			pcfg = ((d & 8'h42) != 8'h00) ? 8'h5A : 8'h18;
			if ((d & 8'h24) != 8'h00) begin
				mreset();
			end
		end
		if (a == 13'h00FF && d == 8'h01) begin
			n = 0;
			while (xfer_seen !== 1'b1 && n < 100) begin
				@(posedge clk_sys);
				n++;
			end
			@(posedge clk_sys);
			#1;
			act_a = sh_a;
			act_b = sh_b;
		end
	endtask : dw
	task automatic dr(input logic [12:0] a, input logic [7:0] e);
		logic [7:0] q;
		spi(2'h1, a, 8'h00, 3'b010, q);
		chk(24'(q), 24'(e));
		chk(frame, {3'b100, a, e});
	endtask : dr
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	// ========================================
	// Main sequence
	initial begin
		logic [12:0] a;
		logic [7:0] q;
		int j;
		void'($urandom(37));
		mreset();
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		cact();
		chk(24'(lsb_first), 24'h000000);
		dr(13'h0000, 8'h18);
		dr(13'h0005, 8'h03);
		for (int c = 1; c < 3; c++) begin
			dw(13'h0005, 8'(c));
			dr(13'h0001, ID_VAL);
			dr(13'h0002, GRADE_VAL);
		end
		for (int k = 0; k < 10; k++) begin
			j = $urandom_range(29);
			a = (j < 25) ? 13'(j + 8) : 13'(j + 33);
			dw(13'h0005, 8'($urandom_range(3, 1)));
			dw(a, 8'($urandom));
			if (chan != 2'h3) begin
				dr(a, chan[0] ? sh_a[j] : sh_b[j]);
			end
		end
		cact();
		dw(13'h0005, 8'h01);
		dw(13'h0010, 8'hA5);
		dw(13'h0005, 8'h02);
		dw(13'h0010, 8'h5A);
		dr(13'h0010, 8'h5A);
		dw(13'h0005, 8'h03);
		dw(13'h003E, 8'hC3);
		dw(13'h0005, 8'h01);
		dr(13'h003E, 8'hC3);
		dw(13'h0005, 8'h02);
		dr(13'h003E, 8'hC3);
		cact();
		dw(13'h00FF, 8'h01);
		cact();
		dr(13'h00FF, 8'h00);
		dw(13'h0005, 8'h03);
		spi(2'h1, 13'h0010, 8'h00, 3'b110, q);
		spi(2'h0, 13'h0003, 8'h55, 3'b110, q);
		dw(13'h0005, 8'hFF);
		dr(13'h0005, 8'h03);
		dw(13'h0000, 8'hC3);
		dr(13'h0000, pcfg);
		chk(24'(lsb_first), 24'h000001);
		dw(13'h0000, 8'h24);
		cact();
		dr(13'h0000, pcfg);
		dw(13'h0010, 8'h3C);
		cact();
		spi(2'h2, 13'h0010, 8'h00, 3'b010, q);
		chk(frame, {3'b000, 13'h00FF, 8'h01});
		act_a = sh_a;
		act_b = sh_b;
		cact();
		test_done();
	end
endmodule : shadowed_spi_register_bank_tb
